// [design/sfplc_pkg.sv]
package sfplc_pkg;

   // protocol selected by the configuration registers
   typedef enum logic [1:0] {
      SFPLC_EXTENDED,
      SFPLC_DUAL_IO,
      SFPLC_QUAD_IO
   } sfplc_proto_t;

   // lane width of the command in progress (extended protocol)
   typedef enum logic [1:0] {
      SFPLC_W_SINGLE,
      SFPLC_W_DUAL,
      SFPLC_W_QUAD
   } sfplc_width_t;

   localparam int unsigned SFPLC_LANES     = 4;
   localparam int unsigned SFPLC_SYNC_W    = 6;
   // bit positions inside the synchronised pin vector
   localparam int unsigned SFPLC_POS_SCLK  = 5;
   localparam int unsigned SFPLC_POS_SEL   = 4;
   localparam int unsigned SFPLC_POS_WP    = 2;
   localparam int unsigned SFPLC_POS_PAUSE = 3;
   // output enable patterns per lane width
   localparam logic [3:0]  SFPLC_OE_NONE   = 4'h0;
   localparam logic [3:0]  SFPLC_OE_SINGLE = 4'h2;
   localparam logic [3:0]  SFPLC_OE_DUAL   = 4'h3;
   localparam logic [3:0]  SFPLC_OE_QUAD   = 4'hF;
   // reset values; sclk idles low so no false edge follows reset
   localparam logic [5:0]  SFPLC_SYNC_RST  = 6'h1F;
   localparam logic [3:0]  SFPLC_DATA_RST  = 4'h0;

endpackage : sfplc_pkg

// [design/sfplc_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module sfplc_sync
   import sfplc_pkg::*;
#(
   parameter int unsigned         WIDTH   = SFPLC_SYNC_W,
   parameter logic [WIDTH-1:0]    RST_VAL = SFPLC_SYNC_RST
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pins_async,
   output logic      [WIDTH-1:0] pins_sync
);

   // two flops per bit; the first stage feeds only the second
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_r       <= RST_VAL[i];
            pins_sync[i] <= RST_VAL[i];
         end else begin
            meta_r       <= pins_async[i];
            pins_sync[i] <= meta_r;
         end
      end
   end

endmodule // sfplc_sync
`default_nettype wire

// [design/sfplc_lane_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module sfplc_lane_ctrl
   import sfplc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   // pins to and from the host
   input  wire logic         sel_n_pin,
   input  wire logic         sclk_pin,
   input  wire logic [3:0]   lane_pin,
   output logic      [3:0]   lane_drv,
   output logic      [3:0]   lane_oe,
   // configuration and core status, same clock domain
   input  wire sfplc_proto_t proto_mode,
   input  wire sfplc_width_t cmd_width,
   input  wire logic         quad_read_cmd,
   input  wire logic         dtr_en,
   input  wire logic         cmd_phase,
   input  wire logic         pause_cfg_en,
   input  wire logic         pause_shared,
   input  wire logic         sr_wr_disable,
   input  wire logic         wrsr_req,
   input  wire logic         busy,
   input  wire logic [3:0]   tx_bits,
   input  wire logic         tx_en,
   // results towards the core
   output logic      [3:0]   rx_data,
   output logic              rx_valid,
   output logic              wrsr_exec,
   output logic              wrsr_refused,
   output logic              sr_locked,
   output logic              standby,
   output logic              pause_active
);

   logic [5:0] pins_s;
   logic       sclk_s;
   logic       sel_s;
   logic       wp_s;
   logic       pause_n_s;
   logic [3:0] lane_s;
   logic       sclk_q_r;
   logic       rise_e;
   logic       fall_e;
   logic       quad_mode;
   logic       dual_mode;
   logic       wp_as_lane;
   logic       pause_en;
   logic [3:0] oe_mask;
   logic [3:0] rx_mask;
   logic       link_live;
   logic       cap_e;
   logic       drv_e;
   logic       pause_act_r;
   logic [3:0] lane_o_r;
   logic [3:0] lane_oe_r;
   logic [3:0] rx_data_r;
   logic       rx_valid_r;
   logic       wrsr_exec_r;
   logic       wrsr_refused_r;
   logic       standby_r;

   // pins cross into the clk domain
   sfplc_sync #(
      .WIDTH   (SFPLC_SYNC_W),
      .RST_VAL (SFPLC_SYNC_RST)
   ) u_sync (
      .clk        (clk),
      .rst_n      (rst_n),
      .pins_async ({sclk_pin, sel_n_pin, lane_pin}),
      .pins_sync  (pins_s)
   );

   assign sclk_s    = pins_s[SFPLC_POS_SCLK];
   assign sel_s     = pins_s[SFPLC_POS_SEL];
   assign wp_s      = pins_s[SFPLC_POS_WP];
   assign pause_n_s = pins_s[SFPLC_POS_PAUSE];
   assign lane_s    = pins_s[3:0];

   // serial clock edge detection on synchronised copy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q_r <= 1'b0;
      end else begin
         sclk_q_r <= sclk_s;
      end
   end

   assign rise_e = sclk_s & ~sclk_q_r;
   assign fall_e = ~sclk_s & sclk_q_r;

   // lane width decode per protocol and command
   assign quad_mode  = (proto_mode == SFPLC_QUAD_IO) ||
                       (proto_mode == SFPLC_EXTENDED && cmd_width == SFPLC_W_QUAD);
   assign dual_mode  = (proto_mode == SFPLC_DUAL_IO) ||
                       (proto_mode == SFPLC_EXTENDED && cmd_width == SFPLC_W_DUAL);
   assign wp_as_lane = (proto_mode == SFPLC_QUAD_IO) ||
                       (proto_mode == SFPLC_EXTENDED && quad_read_cmd);

   // lane direction masks; single width keeps lane 0 in, lane 1 out
   always_comb begin
      if (quad_mode) begin
         oe_mask = SFPLC_OE_QUAD;
         rx_mask = SFPLC_OE_QUAD;
      end else if (dual_mode) begin
         oe_mask = SFPLC_OE_DUAL;
         rx_mask = SFPLC_OE_DUAL;
      end else begin
         oe_mask = SFPLC_OE_SINGLE;
         rx_mask = 4'h1;
      end
   end

   // pause is dropped on a shared pin in quad protocol or double rate
   assign pause_en = pause_cfg_en &&
                     !(pause_shared && (proto_mode == SFPLC_QUAD_IO || dtr_en));

   // pause request, lane 3 level counts only while pause is enabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pause_act_r <= 1'b0;
      end else begin
         pause_act_r <= pause_en && !sel_s && !pause_n_s;
      end
   end

   // link is usable while selected and not paused
   assign link_live = !sel_s && !pause_act_r;
   // command sampled on rise only; double rate data on both edges
   assign cap_e = link_live && (rise_e || (dtr_en && !cmd_phase && fall_e));
   assign drv_e = link_live && (fall_e || (dtr_en && !cmd_phase && rise_e));

   // input capture with lane mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_data_r  <= SFPLC_DATA_RST;
         rx_valid_r <= 1'b0;
      end else begin
         rx_valid_r <= cap_e;
         if (cap_e) begin
            rx_data_r <= lane_s & rx_mask;
         end
      end
   end

   // output drive, floated on deselect or pause
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lane_o_r  <= SFPLC_DATA_RST;
         lane_oe_r <= SFPLC_OE_NONE;
      end else if (!link_live) begin
         lane_oe_r <= SFPLC_OE_NONE;
      end else if (drv_e) begin
         lane_o_r  <= tx_bits & oe_mask;
         lane_oe_r <= tx_en ? oe_mask : SFPLC_OE_NONE;
      end
   end

   // hardware lock of the status register
   assign sr_locked = sr_wr_disable && !wp_s && !wp_as_lane;

   // write-status request accepted or refused
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrsr_exec_r    <= 1'b0;
         wrsr_refused_r <= 1'b0;
      end else begin
         wrsr_exec_r    <= wrsr_req && !sr_locked;
         wrsr_refused_r <= wrsr_req && sr_locked;
      end
   end

   // standby while deselected and idle inside
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         standby_r <= 1'b1;
      end else begin
         standby_r <= sel_s && !busy;
      end
   end

   assign lane_drv     = lane_o_r;
   assign lane_oe      = lane_oe_r;
   assign rx_data      = rx_data_r;
   assign rx_valid     = rx_valid_r;
   assign wrsr_exec    = wrsr_exec_r;
   assign wrsr_refused = wrsr_refused_r;
   assign standby      = standby_r;
   assign pause_active = pause_act_r;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_shared_pause_off: assert property (
      pause_shared && (proto_mode == SFPLC_QUAD_IO || dtr_en) |=> !pause_act_r)
      else $error("pause honoured on shared lane in quad or double rate");

   a_wrsr_blocked: assert property (
      wrsr_req && sr_wr_disable && !wp_s && !wp_as_lane |=> !wrsr_exec_r && wrsr_refused_r)
      else $error("status write executed while hardware locked");

   a_wp_lane_free: assert property (
      wrsr_req && wp_as_lane |=> wrsr_exec_r && !wrsr_refused_r)
      else $error("lane 2 level treated as write protect");

   a_single_dirs: assert property (
      drv_e && tx_en && !quad_mode && !dual_mode |=> lane_oe_r == SFPLC_OE_SINGLE && lane_o_r[0] == 1'b0)
      else $error("single width lanes driven wrong");

   a_dual_dirs: assert property (
      drv_e && tx_en && dual_mode && !quad_mode |=> lane_oe_r == SFPLC_OE_DUAL && lane_o_r[3:2] == 2'b00)
      else $error("dual width lanes driven wrong");

   a_quad_dirs: assert property (
      cap_e && quad_mode |=> rx_valid_r && rx_data_r == $past(lane_s))
      else $error("quad capture lost lanes");

   a_deselect_hiz: assert property (
      sel_s |=> lane_oe_r == SFPLC_OE_NONE && !rx_valid_r && standby_r == !$past(busy))
      else $error("deselected device still active");

   a_cmd_rise_only: assert property (
      fall_e && cmd_phase |=> !rx_valid_r)
      else $error("command sampled on falling edge");

   a_pause_hiz: assert property (
      pause_act_r |=> lane_oe_r == SFPLC_OE_NONE && !rx_valid_r)
      else $error("paused link still drives or samples");

   a_lane3_no_pause: assert property (
      !pause_en |=> !pause_act_r)
      else $error("lane 3 level taken as pause");

endmodule // sfplc_lane_ctrl
`default_nettype wire

// [testbench/sfplc_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sfplc_host_model
   import sfplc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [3:0] dev_data,
   input  wire logic [3:0] dev_oe,
   output logic            sel_n,
   output logic            sclk,
   output logic [3:0]      lane
);
   logic [3:0] drv_r;
   // lanes the device drives win, the host drives the others (lanes 3:2 high when unused)
   always_comb lane = (dev_oe & dev_data) | (~dev_oe & drv_r);
   initial begin
      sel_n = 1'b1;
      sclk  = 1'b0;
      drv_r = 4'hF;
   end
   // select changes only with sclk low, so a falling select precedes every command
   task automatic sel(input logic v);
      @(negedge clk);
      sel_n = v;
      repeat (4) @(negedge clk);
   endtask
   // static lane levels set on a falling clk edge with no sclk edge, then held four cycles
   task automatic set_lanes(input logic [3:0] d);
      @(negedge clk);
      drv_r = d;
      repeat (4) @(negedge clk);
   endtask
   // data set up one cycle ahead of the rise, then the clock stays high four cycles
   task automatic rise(input logic [3:0] d);
      drv_r = d;
      @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // three low cycles here plus the setup cycle of the next rise give an 80 ns period
   task automatic fall();
      sclk = 1'b0;
      repeat (3) @(negedge clk);
   endtask
endmodule // sfplc_host_model
`default_nettype wire

// [testbench/sfplc_lane_ctrl_test.sv]
`timescale 1ns/100ps
`default_nettype none
module sfplc_lane_ctrl_test
   import sfplc_pkg::*;
;
   logic         clk, rst_n, sel_n_pin, sclk_pin, dtr_en, cmd_phase, pause_cfg_en, pause_shared;
   logic         sr_wr_disable, wrsr_req, busy, tx_en, quad_read_cmd, rx_valid, wrsr_exec;
   logic         wrsr_refused, sr_locked, standby, pause_active;
   logic [3:0]   lane_pin, lane_drv, lane_oe, tx_bits, rx_data, rx_last;
   sfplc_proto_t proto_mode;
   sfplc_width_t cmd_width;
   int           n_mismatch = 0, checks_done = 0, rx_cnt = 0, cyc = 0;

   sfplc_lane_ctrl i_sfplc_lane_ctrl (.clk(clk), .rst_n(rst_n), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
      .lane_pin(lane_pin), .lane_drv(lane_drv), .lane_oe(lane_oe), .proto_mode(proto_mode), .cmd_width(cmd_width),
      .quad_read_cmd(quad_read_cmd), .dtr_en(dtr_en), .cmd_phase(cmd_phase), .pause_cfg_en(pause_cfg_en),
      .pause_shared(pause_shared), .sr_wr_disable(sr_wr_disable), .wrsr_req(wrsr_req), .busy(busy),
      .tx_bits(tx_bits), .tx_en(tx_en), .rx_data(rx_data), .rx_valid(rx_valid), .wrsr_exec(wrsr_exec),
      .wrsr_refused(wrsr_refused), .sr_locked(sr_locked), .standby(standby), .pause_active(pause_active));
   sfplc_host_model i_sfplc_host_model (.clk(clk), .dev_data(lane_drv), .dev_oe(lane_oe), .sel_n(sel_n_pin),
      .sclk(sclk_pin), .lane(lane_pin));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // count captures, keep the last one, cut a hang short; sampled where outputs are settled
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1) begin
         rx_last <= rx_data;
         rx_cnt  <= rx_cnt + 1;
      end
      if (cyc == 20000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // capture and drive for each protocol and command width
   task automatic t_lanes();
      sfplc_proto_t p [5] = '{SFPLC_EXTENDED, SFPLC_EXTENDED, SFPLC_DUAL_IO, SFPLC_EXTENDED, SFPLC_QUAD_IO};
      sfplc_width_t w [5] = '{SFPLC_W_SINGLE, SFPLC_W_DUAL, SFPLC_W_SINGLE, SFPLC_W_QUAD, SFPLC_W_SINGLE};
      logic [3:0]   rx [5] = '{4'h1, 4'h3, 4'h3, 4'hB, 4'hB};
      logic [3:0]   oe [5] = '{SFPLC_OE_SINGLE, SFPLC_OE_DUAL, SFPLC_OE_DUAL, SFPLC_OE_QUAD, SFPLC_OE_QUAD};
      int n;
      for (int k = 0; k < 5; k++) begin
         proto_mode = p[k];
         cmd_width  = w[k];
         tx_bits    = 4'hC + 4'(k);
         n = rx_cnt;
         i_sfplc_host_model.sel(1'b0);
         i_sfplc_host_model.rise(4'hB);
         check(4'(rx_cnt - n), 4'h1);
         check(rx_last, rx[k]);
         check(lane_oe, SFPLC_OE_NONE);
         tx_en = 1'b1;
         i_sfplc_host_model.fall();
         check(lane_oe, oe[k]);
         check(lane_drv & oe[k], tx_bits & oe[k]);
         i_sfplc_host_model.sel(1'b1);
         tx_en = 1'b0;
         check(lane_oe, SFPLC_OE_NONE);
      end
      $display("lane test done");
   endtask

   // double rate captures and drives on both edges except in the command phase
   task automatic t_rate();
      int n;
      proto_mode = SFPLC_EXTENDED;
      cmd_width  = SFPLC_W_QUAD;
      tx_en      = 1'b1;
      i_sfplc_host_model.sel(1'b0);
      for (int k = 0; k < 4; k++) begin
         {dtr_en, cmd_phase} = 2'(k);
         tx_bits = 4'h8 + 4'(k);
         n = rx_cnt;
         i_sfplc_host_model.rise(4'h6);
         check({3'h0, lane_drv == tx_bits}, {3'h0, k == 2});
         tx_bits = 4'h1 + 4'(k);
         i_sfplc_host_model.fall();
         check(lane_drv, tx_bits);
         check(lane_oe, SFPLC_OE_QUAD);
         @(negedge clk);
         check(4'(rx_cnt - n), (k == 2) ? 4'h2 : 4'h1);
      end
      i_sfplc_host_model.sel(1'b1);
      {dtr_en, cmd_phase, tx_en} = 3'h0;
      $display("rate test done");
   endtask

   // deselected: standby is high only while not busy, clock edges are ignored
   task automatic t_standby();
      int n;
      for (int b = 0; b < 2; b++) begin
         busy = 1'(b);
         n = rx_cnt;
         i_sfplc_host_model.rise(4'hF);
         i_sfplc_host_model.fall();
         check({3'h0, standby}, {3'h0, b == 0});
         check(4'(rx_cnt - n), 4'h0);
         check(lane_oe, SFPLC_OE_NONE);
      end
      busy = 1'b0;
      $display("standby test done");
   endtask

   // pause on lane 3, shared pin first: masked by double rate and quad protocol only when shared
   task automatic t_pause();
      int n;
      proto_mode   = SFPLC_EXTENDED;
      cmd_width    = SFPLC_W_SINGLE;
      pause_cfg_en = 1'b1;
      i_sfplc_host_model.sel(1'b0);
      for (int k = 0; k < 2; k++) begin
         pause_shared = ~k[0];
         n = rx_cnt;
         i_sfplc_host_model.rise(4'h7);
         check({3'h0, pause_active}, 4'h1);
         check(4'(rx_cnt - n), 4'h0);
         i_sfplc_host_model.fall();
         dtr_en = 1'b1;
         i_sfplc_host_model.set_lanes(4'h7);
         check({3'h0, pause_active}, {3'h0, k[0]});
         dtr_en = 1'b0;
         proto_mode = SFPLC_QUAD_IO;
         i_sfplc_host_model.set_lanes(4'h7);
         check({3'h0, pause_active}, {3'h0, k[0]});
         proto_mode = SFPLC_EXTENDED;
         i_sfplc_host_model.set_lanes(4'hF);
         check({3'h0, pause_active}, 4'h0);
      end
      i_sfplc_host_model.sel(1'b1);
      pause_cfg_en = 1'b0;
      $display("pause test done");
   endtask

   // write status: {disable bit, lane 2, quad read, quad protocol, locked}
   task automatic t_wrsr();
      logic [4:0] c [5] = '{5'h11, 5'h18, 5'h00, 5'h14, 5'h12};
      logic ex, rf;
      for (int k = 0; k < 5; k++) begin
         sr_wr_disable = c[k][4];
         quad_read_cmd = c[k][2];
         proto_mode    = c[k][1] ? SFPLC_QUAD_IO : SFPLC_EXTENDED;
         i_sfplc_host_model.set_lanes({1'b1, c[k][3], 2'h3});
         check({3'h0, sr_locked}, {3'h0, c[k][0]});
         wrsr_req = 1'b1;
         @(negedge clk);
         wrsr_req = 1'b0;
         ex = wrsr_exec;
         rf = wrsr_refused;
         @(negedge clk);
         ex = ex | wrsr_exec;
         rf = rf | wrsr_refused;
         check({2'h0, ex, rf}, {2'h0, !c[k][0], c[k][0]});
      end
      $display("write status test done");
   endtask

   initial begin
      rst_n = 1'b0;
      {dtr_en, cmd_phase, pause_cfg_en, pause_shared, sr_wr_disable, wrsr_req, busy, tx_en} = 8'h00;
      quad_read_cmd = 1'b0;
      tx_bits = 4'hF;
      proto_mode = SFPLC_EXTENDED;
      cmd_width = SFPLC_W_SINGLE;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      check(lane_oe, SFPLC_OE_NONE);
      check({3'h0, pause_active}, 4'h0);
      t_lanes();
      t_rate();
      t_standby();
      t_pause();
      t_wrsr();
      test_done();
   end
endmodule // sfplc_lane_ctrl_test
`default_nettype wire
